// ### verilog/rdd_pkg.sv
// Purpose: Shared constants and carriers for the remap entry delivery decoder.
// Assumes: Entries arrive as 64-bit words from the table fetch logic.
// Notes:   Register map, entry field positions and delivery codes.
package rdd_pkg;
	////////////////////////////////////////////////////////////////////////////
	localparam int          ENTRY_W          = 64;
	localparam int          PRESENT_BIT      = 0;
	localparam int          TRIG_BIT         = 4;
	localparam int          DSEL_LSB         = 5;
	localparam int          DSEL_MSB         = 7;
	localparam int          VEC_LSB          = 16;
	localparam int          VEC_MSB          = 23;
	localparam int          TGT_LSB          = 32;
	localparam int          TGT_MSB          = 63;
	localparam int          TGT_W            = 32;
	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0]
	{
		RDD_DSEL_FIXED  = 3'b000,
		RDD_DSEL_LOWEST = 3'b001,
		RDD_DSEL_SMGMT  = 3'b010,
		RDD_DSEL_NMI    = 3'b100,
		RDD_DSEL_INIT   = 3'b101
	} rdd_dsel_t;
	localparam logic        TRIG_EDGE        = 1'b0;
	localparam logic        TRIG_LEVEL       = 1'b1;
	localparam logic [7:0]  VEC_NONE         = 8'h00;
	////////////////////////////////////////////////////////////////////////////
	localparam logic [11:0] OFF_CTRL         = 12'h000;
	localparam logic [11:0] OFF_BLOCKED      = 12'h004;
	localparam logic [11:0] OFF_INVALID      = 12'h008;
	localparam logic [11:0] OFF_LAST         = 12'h00c;
	localparam logic [3:0]  CTRL_RESET       = 4'h0;
	localparam int          CTRL_SMGMT_EN    = 0;
	localparam int          CTRL_INIT_EN     = 1;
	localparam int          CTRL_NMI_PIN     = 2;
	localparam int          CTRL_SMGMT_PIN   = 3;
	////////////////////////////////////////////////////////////////////////////
	typedef struct packed
	{
		logic               valid;
		logic [ENTRY_W-1:0] entry;
	} rdd_req_t;

	typedef struct packed
	{
		logic               valid;
		logic [2:0]         mode;
		logic               level;
		logic [7:0]         vector;
		logic [TGT_W-1:0]   target;
		logic               single;
	} rdd_dlv_t;
endpackage

// ### verilog/rdd_top.sv
// Purpose: Decodes delivery selection and trigger type of remapped interrupt entries.
// Assumes: Requests come from logic on pclk; registers are reached over APB.
// Notes:   Target identifier is handled as a bitmask of agents.
//
// Overview of operation
// - Delivery selection is entry bits 7:5.
// - Fixed code delivers to all named agents, edge or level.
// - Lowest-priority code delivers to exactly one named agent, edge or level.
// - System-management code is forced edge and its vector ignored.
// - Non-maskable code goes to all named agents, vector ignored, forced edge.
// - Processor-init code goes to all named agents, vector ignored, forced edge.
// - System-management and init support optional; NMI may leave by dedicated pin.
// - Trigger bit 4: zero edge, one level.
// - Trigger bit evaluated only when entry is present.
// - Non-present entries block requests; present ones are processed.
// - Vector is entry bits 23:16 unless the code ignores it.
`timescale 1ns/10ps
module rdd_top
#(
	parameter int CNT_W = 16
)
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire rdd_pkg::rdd_req_t req,
	output rdd_pkg::rdd_dlv_t      dlv,
	output logic                   nmi_pin,
	output logic                   smgmt_pin,
	output logic                   req_blocked,
	output logic                   req_invalid
);
	////////////////////////////////////////////////////////////////////////////
	// Picking the lowest set bit keeps the single-target choice deterministic.
	function automatic logic [rdd_pkg::TGT_W-1:0] lowest_one(input logic [rdd_pkg::TGT_W-1:0] m);
		logic [rdd_pkg::TGT_W-1:0] r;
		r = '0;
		for (int i = rdd_pkg::TGT_W - 1; i >= 0; i--)
		begin
			if (m[i])
			begin
				r    = '0;
				r[i] = 1'b1;
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic [3:0]       ctrl_reg, ctrl_next;
	logic [CNT_W-1:0] blocked_reg, blocked_next;
	logic [CNT_W-1:0] invalid_reg, invalid_next;
	logic [31:0]      prdata_reg, prdata_next;
	logic             pready_reg, pready_next;
	logic             pslverr_reg, pslverr_next;
	rdd_pkg::rdd_dlv_t dlv_reg, dlv_next;
	logic             nmi_reg, nmi_next;
	logic             smgmt_reg, smgmt_next;
	logic             blk_reg, blk_next;
	logic             inv_reg, inv_next;

	logic             wr_take;
	logic [2:0]       dsel;
	logic             trig;
	logic [7:0]       vec;
	logic [rdd_pkg::TGT_W-1:0] tgt;

	assign wr_take = psel && penable && pready_reg && pwrite;
	assign dsel    = req.entry[rdd_pkg::DSEL_MSB:rdd_pkg::DSEL_LSB];
	assign trig    = req.entry[rdd_pkg::TRIG_BIT];
	assign vec     = req.entry[rdd_pkg::VEC_MSB:rdd_pkg::VEC_LSB];
	assign tgt     = req.entry[rdd_pkg::TGT_MSB:rdd_pkg::TGT_LSB];

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		dlv_next   = '0;
		nmi_next   = 1'b0;
		smgmt_next = 1'b0;
		blk_next   = 1'b0;
		inv_next   = 1'b0;
		if (req.valid)
		begin
			if (!req.entry[rdd_pkg::PRESENT_BIT])
			begin
				blk_next = 1'b1;
			end
			else
			begin
				dlv_next.mode = dsel;
				case (dsel)
					rdd_pkg::RDD_DSEL_FIXED:
					begin
						dlv_next.valid  = 1'b1;
						dlv_next.level  = (trig == rdd_pkg::TRIG_LEVEL);
						dlv_next.vector = vec;
						dlv_next.target = tgt;
					end
					rdd_pkg::RDD_DSEL_LOWEST:
					begin
						dlv_next.valid  = 1'b1;
						dlv_next.level  = (trig == rdd_pkg::TRIG_LEVEL);
						dlv_next.vector = vec;
						dlv_next.target = lowest_one(tgt);
						dlv_next.single = 1'b1;
					end
					rdd_pkg::RDD_DSEL_SMGMT:
					begin
						if (ctrl_reg[rdd_pkg::CTRL_SMGMT_EN])
						begin
							dlv_next.level  = rdd_pkg::TRIG_EDGE;
							dlv_next.vector = rdd_pkg::VEC_NONE;
							if (ctrl_reg[rdd_pkg::CTRL_SMGMT_PIN])
								smgmt_next = 1'b1;
							else
							begin
								dlv_next.valid  = 1'b1;
								dlv_next.target = tgt;
							end
						end
						else
							inv_next = 1'b1;
					end
					rdd_pkg::RDD_DSEL_NMI:
					begin
						dlv_next.level  = rdd_pkg::TRIG_EDGE;
						dlv_next.vector = rdd_pkg::VEC_NONE;
						if (ctrl_reg[rdd_pkg::CTRL_NMI_PIN])
							nmi_next = 1'b1;
						else
						begin
							dlv_next.valid  = 1'b1;
							dlv_next.target = tgt;
						end
					end
					rdd_pkg::RDD_DSEL_INIT:
					begin
						if (ctrl_reg[rdd_pkg::CTRL_INIT_EN])
						begin
							dlv_next.valid  = 1'b1;
							dlv_next.level  = rdd_pkg::TRIG_EDGE;
							dlv_next.vector = rdd_pkg::VEC_NONE;
							dlv_next.target = tgt;
						end
						else
							inv_next = 1'b1;
					end
					default:
					begin
						inv_next      = 1'b1;
						dlv_next.mode = 3'b000;
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dlv_reg   <= '0;
			nmi_reg   <= 1'b0;
			smgmt_reg <= 1'b0;
			blk_reg   <= 1'b0;
			inv_reg   <= 1'b0;
		end
		else
		begin
			dlv_reg   <= dlv_next;
			nmi_reg   <= nmi_next;
			smgmt_reg <= smgmt_next;
			blk_reg   <= blk_next;
			inv_reg   <= inv_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data is prepared in the setup cycle so every transfer ends in one access cycle.
	always_comb
	begin
		ctrl_next    = ctrl_reg;
		blocked_next = blocked_reg;
		invalid_next = invalid_reg;
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		pready_next  = psel && !penable;
		if (blk_reg && blocked_reg != {CNT_W{1'b1}})
			blocked_next = blocked_reg + 1'b1;
		if (inv_reg && invalid_reg != {CNT_W{1'b1}})
			invalid_next = invalid_reg + 1'b1;
		if (psel && !penable)
		begin
			prdata_next = 32'h0000_0000;
			case (paddr)
				rdd_pkg::OFF_CTRL:    prdata_next[3:0] = ctrl_reg;
				rdd_pkg::OFF_BLOCKED: prdata_next[CNT_W-1:0] = blocked_reg;
				rdd_pkg::OFF_INVALID: prdata_next[CNT_W-1:0] = invalid_reg;
				rdd_pkg::OFF_LAST:    prdata_next[12:0] = {dlv_reg.single, dlv_reg.level, dlv_reg.mode, dlv_reg.vector};
				default:              pslverr_next = 1'b1;
			endcase
		end
		else if (psel && penable && pready_reg)
			pslverr_next = 1'b0;
		else
			pslverr_next = pslverr_reg && psel;
		if (wr_take)
		begin
			case (paddr)
				rdd_pkg::OFF_CTRL:    ctrl_next = pwdata[3:0];
				// Software clear keeps a count in the same cycle by starting from one.
				rdd_pkg::OFF_BLOCKED: blocked_next = {{(CNT_W-1){1'b0}}, blk_reg};
				rdd_pkg::OFF_INVALID: invalid_next = {{(CNT_W-1){1'b0}}, inv_reg};
				default:              ctrl_next = ctrl_reg;
			endcase
		end
		if (psel && penable && pready_reg)
			pslverr_next = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg    <= rdd_pkg::CTRL_RESET;
			blocked_reg <= '0;
			invalid_reg <= '0;
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			ctrl_reg    <= ctrl_next;
			blocked_reg <= blocked_next;
			invalid_reg <= invalid_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata      = prdata_reg;
	assign pready      = pready_reg;
	assign pslverr     = pslverr_reg;
	assign dlv         = dlv_reg;
	assign nmi_pin     = nmi_reg;
	assign smgmt_pin   = smgmt_reg;
	assign req_blocked = blk_reg;
	assign req_invalid = inv_reg;
endmodule

// ### bench/rdd_top_properties.sv
// Purpose: Port relations of the delivery decoder.
// Assumes: One clock, presetn low resets.
// Notes:   Bound to rdd_top.
`timescale 1ns/10ps
module rdd_top_properties
(
	input logic              pclk,
	input logic              presetn,
	input logic              psel,
	input logic              penable,
	input logic              pready,
	input rdd_pkg::rdd_req_t req,
	input rdd_pkg::rdd_dlv_t dlv,
	input logic              nmi_pin,
	input logic              smgmt_pin,
	input logic              req_blocked,
	input logic              req_invalid
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [2:0] c;
	logic       p;
	assign c = req.entry[7:5];
	assign p = req.valid && req.entry[0];
	////////////////////////////////////////////////////////////////
	chk_apb_ready: assert property (psel && !penable |=> pready) else $error("pready late");
	chk_block_absent: assert property (req.valid && !req.entry[0] |=> req_blocked && !dlv.valid)
		else $error("absent entry not blocked");
	chk_code_undef: assert property (p && c inside {3'h3, 3'h6, 3'h7} |=> req_invalid && !dlv.valid)
		else $error("undefined code delivered");
	chk_fixed_all: assert property (p && c == 3'h0 |=> dlv.valid && !dlv.single && dlv.target == $past(req.entry[63:32]))
		else $error("fixed target wrong");
	chk_lowest_one: assert property (p && c == 3'h1 |=> dlv.valid && dlv.single && $onehot0(dlv.target))
		else $error("lowest not single");
	chk_forced_edge: assert property (p && c inside {3'h2, 3'h4, 3'h5} |=> !dlv.level && dlv.vector == 8'h00)
		else $error("edge or vector wrong");
	chk_trig_bit: assert property (p && c < 3'h2 |=> dlv.level == $past(req.entry[4]))
		else $error("level wrong");
	chk_vector_take: assert property (p && c < 3'h2 |=> dlv.vector == $past(req.entry[23:16]))
		else $error("vector wrong");
	chk_mode_field: assert property (p |=> !dlv.valid || dlv.mode == $past(c)) else $error("mode wrong");
	chk_one_answer: assert property (req.valid |=> $onehot({dlv.valid, nmi_pin, smgmt_pin, req_blocked, req_invalid}))
		else $error("answer count wrong");
	cover property (p && c == 3'h1);
	cover property (nmi_pin);
	cover property (req_invalid);
endmodule
bind rdd_top rdd_top_properties rdd_top_properties_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .req(req), .dlv(dlv), .nmi_pin(nmi_pin), .smgmt_pin(smgmt_pin),
	.req_blocked(req_blocked), .req_invalid(req_invalid));

// ### bench/rdd_cpu_model.sv
// Purpose: Target processor side; keeps the last agent mask it was given.
// Assumes: Deliveries are one-cycle pulses.
// Notes:   Pin-routed signals are watched by the bench itself.
`timescale 1ns/10ps
module rdd_cpu_model
(
	input  logic              pclk,
	input  logic              presetn,
	input  rdd_pkg::rdd_dlv_t dlv,
	output logic [31:0]       seen_target_reg
);
	logic [31:0] seen_target_next;
	always_comb
	begin
		seen_target_next = dlv.valid ? dlv.target : seen_target_reg;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			seen_target_reg <= 32'h0000_0000;
		else
			seen_target_reg <= seen_target_next;
	end
endmodule

// ### bench/tb_rdd_top.sv
// Purpose: Directed test of the delivery decoder.
// Assumes: Counters shortened to four bits.
// Notes:   Registers are reached by APB tasks.
`timescale 1ns/10ps
module tb_rdd_top;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [11:0]       paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	rdd_pkg::rdd_req_t req;
	rdd_pkg::rdd_dlv_t dlv;
	logic              nmi_pin;
	logic              smgmt_pin;
	logic              req_blocked;
	logic              req_invalid;
	logic [31:0]       seen;
	logic [31:0]       rd;
	logic              er;
	int                num_errors;
	int                check_count;
	logic [2:0]        codes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
	rdd_top #(.CNT_W(4)) rdd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req(req), .dlv(dlv), .nmi_pin(nmi_pin), .smgmt_pin(smgmt_pin), .req_blocked(req_blocked),
		.req_invalid(req_invalid));
	rdd_cpu_model rdd_cpu_model_i (.pclk(pclk), .presetn(presetn), .dlv(dlv), .seen_target_reg(seen));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x)
		begin
			num_errors++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic send(input logic [63:0] e);
		@(posedge pclk);
		req <= '{1'b1, e};
		@(posedge pclk);
		req.valid <= 1'b0;
		#1;
	endtask
	function automatic logic [63:0] ent(input logic [2:0] m, input logic t, input logic [7:0] v);
		return {32'h0000_0c00, 8'h00, v, 8'h00, m, t, 4'h1};
	endfunction
	task automatic final_report();
		if (num_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// The tests need well under 400 cycles; the margin covers slow answers.
	initial
	begin
		#20000;
		num_errors++;
		final_report();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		req = '0;
		num_errors = 0;
		check_count = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, rdd_pkg::OFF_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b1, rdd_pkg::OFF_LAST, 32'hffff_ffff);
		chk(er, 32'h0000_0000);
		apb(1'b0, rdd_pkg::OFF_LAST, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk(er, 32'h0000_0000);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk(er, 32'h0000_0001);
		send(64'h0000_0c00_0000_0040);
		chk(req_blocked, 32'h0000_0001);
		send(ent(3'h3, 1'b0, 8'h00));
		chk(req_invalid, 32'h0000_0001);
		send(ent(3'h2, 1'b0, 8'h00));
		chk(req_invalid, 32'h0000_0001);
		send(ent(3'h5, 1'b0, 8'h00));
		chk(req_invalid, 32'h0000_0001);
		send(ent(3'h7, 1'b0, 8'h00));
		chk(req_invalid, 32'h0000_0001);
		apb(1'b0, rdd_pkg::OFF_INVALID, 32'h0000_0000);
		chk(rd, 32'h0000_0004);
		apb(1'b1, rdd_pkg::OFF_INVALID, 32'h0000_0000);
		apb(1'b0, rdd_pkg::OFF_INVALID, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b1, rdd_pkg::OFF_CTRL, 32'h0000_0003);
		foreach (codes[i])
			for (int t = 0; t < 2; t++)
			begin
				send(ent(codes[i], t[0], codes[i] == 3'h2 ? 8'h00 : 8'h5a));
				chk({dlv.valid, dlv.mode, dlv.level, dlv.vector}, {1'b1, codes[i], codes[i] < 3'h2 && t[0],
					codes[i] < 3'h2 ? 8'h5a : 8'h00});
				chk(dlv.target, codes[i] == 3'h1 ? 32'h0000_0400 : 32'h0000_0c00);
			end
		apb(1'b1, rdd_pkg::OFF_CTRL, 32'h0000_000f);
		chk(seen, 32'h0000_0c00);
		send(ent(3'h4, 1'b0, 8'h00));
		chk({nmi_pin, dlv.valid}, 32'h0000_0002);
		send(ent(3'h2, 1'b0, 8'h00));
		chk({smgmt_pin, dlv.valid}, 32'h0000_0002);
		@(posedge pclk);
		req <= '{1'b1, 64'h0000_0000_0000_0000};
		repeat (16) @(posedge pclk);
		req.valid <= 1'b0;
		apb(1'b0, rdd_pkg::OFF_BLOCKED, 32'h0000_0000);
		chk(rd, 32'h0000_000f);
		final_report();
	end
endmodule
